// [design/vcp_pkg.sv]
// constants, states and state records of the video capture and host port
// assumes nothing beyond a SystemVerilog compiler
package vcp_pkg;

  // ---------------------------------------------------------------
  // widths and layout
  // ---------------------------------------------------------------
  localparam int PIX_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 5;
  localparam int WORD_W = PIX_W + 2;
  localparam int LINE_BIT = PIX_W;
  localparam int FRAME_BIT = PIX_W + 1;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // strobe low cycles before wait release is looked at: covers the pin sync delay
  localparam logic [1:0] STROBE_MIN_CYC = 2'h2;

  // ---------------------------------------------------------------
  // host port sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SETUP = 4'h2,
    HS_STROBE = 4'h4,
    HS_HOLD = 4'h8
  } vcp_host_state_t;

  typedef struct packed {
    vcp_host_state_t st;
    logic [PIX_W-1:0] pin_s1;
    logic [PIX_W-1:0] pin_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic irq_s1;
    logic irq_s2;
    logic dreq_s1;
    logic dreq_s2;
    logic drop_s1;
    logic drop_s2;
    logic drop_s3;
    logic [PIX_W-1:0] strap;
    logic strap_ok;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
    logic wr;
    logic [1:0] cnt;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic req_rdy;
    logic rsp_v;
    logic [BYTE_W-1:0] rdata;
    logic irq;
    logic dreq;
    logic cap_en;
    logic cap16;
    logic pv;
    logic [WORD_W-1:0] pword;
    logic ovf;
  } vcp_top_st_t;

  localparam vcp_top_st_t TOP_RST = '{
    st: HS_IDLE,
    irq_s1: 1'b1,
    irq_s2: 1'b1,
    sel_n: 1'b1,
    rd_n: 1'b1,
    wr_n: 1'b1,
    default: '0
  };

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic m16_s1;
    logic m16_s2;
    logic dv;
    logic line_ref;
    logic vref;
    logic line_ref_d;
    logic vref_d;
    logic [PIX_W-1:0] pix;
    logic line_p;
    logic frame_p;
    logic drop;
  } vcp_cap_st_t;

  localparam vcp_cap_st_t CAP_RST = '{default: '0};

endpackage : vcp_pkg

// [design/vcp_async_fifo.sv]
// dual-clock word fifo with gray-coded pointers
// assumes each side has a reset synchronous to its own clock
`timescale 1ns/1ps
module vcp_async_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic wr_clock_in,
  input wire logic wr_rst_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_clock_in,
  input wire logic rd_rst_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] rg1;
    logic [AW:0] rg2;
  } vcp_fifo_wr_t;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] wg1;
    logic [AW:0] wg2;
  } vcp_fifo_rd_t;

  vcp_fifo_wr_t w_q, w_d;
  vcp_fifo_rd_t r_q, r_d;

  // full when the write pointer is one lap ahead of the synced read pointer
  assign wr_ready_out = w_q.gray != {~w_q.rg2[AW:AW-1], w_q.rg2[AW-2:0]};
  assign rd_valid_out = r_q.gray != r_q.wg2;
  assign rd_data_out = w_q.mem[r_q.bin[AW-1:0]];

  always_comb begin
    w_d = w_q;
    w_d.rg1 = r_q.gray;
    w_d.rg2 = w_q.rg1;
    if (wr_valid_in && wr_ready_out) begin
      w_d.mem[w_q.bin[AW-1:0]] = wr_data_in;
      w_d.bin = w_q.bin + 1'b1;
      w_d.gray = w_d.bin ^ (w_d.bin >> 1);
    end
    if (wr_rst_in) begin
      w_d.bin = '0;
      w_d.gray = '0;
      w_d.rg1 = '0;
      w_d.rg2 = '0;
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.wg1 = w_q.gray;
    r_d.wg2 = r_q.wg1;
    if (rd_valid_out && rd_ready_in) begin
      r_d.bin = r_q.bin + 1'b1;
      r_d.gray = r_d.bin ^ (r_d.bin >> 1);
    end
    if (rd_rst_in) begin
      r_d = '0;
    end
  end

  always_ff @(posedge wr_clock_in) begin
    w_q <= w_d;
  end

  always_ff @(posedge rd_clock_in) begin
    r_q <= r_d;
  end

endmodule : vcp_async_fifo

// [design/vcp_capture_front.sv]
// capture-clock side: pin registers, word build, line/frame marks
// assumes the pins are timed to capture_clock_in by the video source
`timescale 1ns/1ps
module vcp_capture_front import vcp_pkg::*; (
  input wire logic capture_clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic mode16_in,
  input wire logic horizontal_reference_in,
  input wire logic vertical_reference_in,
  input wire logic capture_data_valid_in,
  input wire logic [PIX_W-1:0] capture_pixel_bus_in,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic [WORD_W-1:0] wr_data_out,
  output logic drop_toggle_out,
  output logic cap_rst_out
);
  vcp_cap_st_t q, d;
  logic rst_s1, rst_s2;
  logic line_rise, frame_rise;

  assign cap_rst_out = rst_s2;
  assign drop_toggle_out = q.drop;
  assign line_rise = q.line_ref && !q.line_ref_d;
  assign frame_rise = q.vref && !q.vref_d;
  assign wr_valid_out = q.dv && q.en_s2;
  assign wr_data_out[LINE_BIT] = q.line_p || line_rise;
  assign wr_data_out[FRAME_BIT] = q.frame_p || frame_rise;
  // 8-bit mode lands the upper byte low so both modes share one word format
  assign wr_data_out[PIX_W-1:0] = q.m16_s2 ? q.pix : {8'h00, q.pix[15:8]};

  always_comb begin
    d = q;
    d.en_s1 = enable_in;
    d.en_s2 = q.en_s1;
    d.m16_s1 = mode16_in;
    d.m16_s2 = q.m16_s1;
    d.dv = capture_data_valid_in;
    d.line_ref = horizontal_reference_in;
    d.vref = vertical_reference_in;
    d.line_ref_d = q.line_ref;
    d.vref_d = q.vref;
    d.pix = capture_pixel_bus_in;
    d.line_p = q.line_p || line_rise;
    d.frame_p = q.frame_p || frame_rise;
    if (wr_valid_out) begin
      d.line_p = 1'b0;
      d.frame_p = 1'b0;
      // the source cannot be stalled; a full fifo loses the word
      if (!wr_ready_in) begin
        d.drop = !q.drop;
      end
    end
    if (rst_s2) begin
      d = CAP_RST;
    end
  end

  always_ff @(posedge capture_clock_in) begin
    rst_s1 <= rst_in;
    rst_s2 <= rst_s1;
    q <= d;
  end

  a_valid_only: assert property (@(posedge capture_clock_in) disable iff (rst_s2)
    wr_valid_out |-> $past(capture_data_valid_in) && q.en_s2)
    else $error("capture word written without data valid");

  a_mode8_upper: assert property (@(posedge capture_clock_in) disable iff (rst_s2)
    wr_valid_out && !q.m16_s2 |-> wr_data_out[15:8] == 8'h00
      && wr_data_out[7:0] == $past(capture_pixel_bus_in[15:8]))
    else $error("8-bit capture did not take the upper byte");

endmodule : vcp_capture_front

// [design/vcp_video_port.sv]
// top of the video capture and host port: capture path, fifo, host sequencer
// assumes clock_in and capture_clock_in are unrelated and rst_in is the hard reset
`timescale 1ns/1ps
module vcp_video_port import vcp_pkg::*; #(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic capture_clock_in,
  input wire logic horizontal_reference_in,
  input wire logic vertical_reference_in,
  input wire logic capture_data_valid_in,
  input wire logic [PIX_W-1:0] capture_pixel_bus_in,
  output logic [BYTE_W-1:0] capture_pixel_bus_out,
  output logic capture_pixel_bus_oe_out,
  input wire logic capture_enable_in,
  input wire logic capture_mode16_in,
  output logic pixel_valid_out,
  input wire logic pixel_ready_in,
  output logic [PIX_W-1:0] pixel_data_out,
  output logic pixel_line_start_out,
  output logic pixel_frame_start_out,
  output logic capture_overflow_out,
  input wire logic host_req_valid_in,
  input wire logic host_req_write_in,
  input wire logic [ADDR_W-1:0] host_req_addr_in,
  input wire logic [BYTE_W-1:0] host_req_wdata_in,
  output logic host_req_ready_out,
  output logic host_rsp_valid_out,
  output logic [BYTE_W-1:0] host_rsp_rdata_out,
  output logic [ADDR_W-1:0] host_port_address_out,
  output logic host_port_select_n_out,
  output logic host_port_read_n_out,
  output logic host_port_write_n_out,
  input wire logic host_port_wait_release_in,
  input wire logic dma_data_request_in,
  input wire logic host_port_irq_n_in,
  output logic dma_request_out,
  output logic interrupt_out,
  output logic [PIX_W-1:0] subsystem_id_out,
  output logic subsystem_id_valid_out
);

  // ---------------------------------------------------------------
  // state and wiring
  // ---------------------------------------------------------------
  vcp_top_st_t q, d;
  logic busy_d;
  logic pop;
  logic strobe_low;
  logic cap_wr_valid;
  logic cap_wr_ready;
  logic [WORD_W-1:0] cap_wr_data;
  logic cap_drop_toggle;
  logic cap_rst;
  logic fifo_rvalid;
  logic [WORD_W-1:0] fifo_rdata;

  // ---------------------------------------------------------------
  // capture clock domain and crossing
  // ---------------------------------------------------------------
  vcp_capture_front u_front (
    .capture_clock_in(capture_clock_in),
    .rst_in(rst_in),
    .enable_in(q.cap_en),
    .mode16_in(q.cap16),
    .horizontal_reference_in(horizontal_reference_in),
    .vertical_reference_in(vertical_reference_in),
    .capture_data_valid_in(capture_data_valid_in),
    .capture_pixel_bus_in(capture_pixel_bus_in),
    .wr_valid_out(cap_wr_valid),
    .wr_ready_in(cap_wr_ready),
    .wr_data_out(cap_wr_data),
    .drop_toggle_out(cap_drop_toggle),
    .cap_rst_out(cap_rst)
  );

  vcp_async_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .wr_clock_in(capture_clock_in),
    .wr_rst_in(cap_rst),
    .wr_valid_in(cap_wr_valid),
    .wr_ready_out(cap_wr_ready),
    .wr_data_in(cap_wr_data),
    .rd_clock_in(clock_in),
    .rd_rst_in(rst_in),
    .rd_valid_out(fifo_rvalid),
    .rd_ready_in(pop),
    .rd_data_out(fifo_rdata)
  );

  // ---------------------------------------------------------------
  // outputs, all from state flops
  // ---------------------------------------------------------------
  assign capture_pixel_bus_out = q.wdata;
  assign capture_pixel_bus_oe_out = q.oe;
  assign pixel_valid_out = q.pv;
  assign pixel_data_out = q.pword[PIX_W-1:0];
  assign pixel_line_start_out = q.pword[LINE_BIT];
  assign pixel_frame_start_out = q.pword[FRAME_BIT];
  assign capture_overflow_out = q.ovf;
  assign host_req_ready_out = q.req_rdy;
  assign host_rsp_valid_out = q.rsp_v;
  assign host_rsp_rdata_out = q.rdata;
  assign host_port_address_out = q.addr;
  assign host_port_select_n_out = q.sel_n;
  assign host_port_read_n_out = q.rd_n;
  assign host_port_write_n_out = q.wr_n;
  assign dma_request_out = q.dreq;
  assign interrupt_out = q.irq;
  assign subsystem_id_out = q.strap;
  assign subsystem_id_valid_out = q.strap_ok;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // pin synchronisers; the first stage feeds only the second
    d.pin_s1 = capture_pixel_bus_in;
    d.pin_s2 = q.pin_s1;
    d.rdy_s1 = host_port_wait_release_in;
    d.rdy_s2 = q.rdy_s1;
    d.irq_s1 = host_port_irq_n_in;
    d.irq_s2 = q.irq_s1;
    d.dreq_s1 = dma_data_request_in;
    d.dreq_s2 = q.dreq_s1;
    d.drop_s1 = cap_drop_toggle;
    d.drop_s2 = q.drop_s1;
    d.drop_s3 = q.drop_s2;
    d.irq = !q.irq_s2;
    d.dreq = q.dreq_s2;
    d.rsp_v = 1'b0;
    d.strap_ok = 1'b1;

    case (q.st)
      HS_IDLE: begin
        if (host_req_valid_in && q.req_rdy) begin
          d.addr = host_req_addr_in;
          d.wdata = host_req_wdata_in;
          d.wr = host_req_write_in;
          d.sel_n = 1'b0;
          d.oe = host_req_write_in;
          d.st = HS_SETUP;
        end
      end
      HS_SETUP: begin
        d.rd_n = q.wr;
        d.wr_n = !q.wr;
        d.cnt = STROBE_MIN_CYC;
        d.st = HS_STROBE;
      end
      HS_STROBE: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else if (q.rdy_s2) begin
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          if (!q.wr) begin
            d.rdata = q.pin_s2[BYTE_W-1:0];
          end
          d.st = HS_HOLD;
        end
      end
      HS_HOLD: begin
        // select and write data outlast the strobe by one cycle
        d.sel_n = 1'b1;
        d.oe = 1'b0;
        d.rsp_v = 1'b1;
        d.st = HS_IDLE;
      end
      default: begin
        d.sel_n = 1'b1;
        d.rd_n = 1'b1;
        d.wr_n = 1'b1;
        d.oe = 1'b0;
        d.st = HS_IDLE;
      end
    endcase

    // wide capture and host cycles exclude each other on the shared byte
    busy_d = d.st != HS_IDLE;
    d.req_rdy = !busy_d && !(capture_enable_in && capture_mode16_in);
    d.cap_en = capture_enable_in && !(capture_mode16_in && busy_d);
    d.cap16 = capture_mode16_in;

    // output stage refills whenever it is empty or being taken
    pop = fifo_rvalid && (!q.pv || pixel_ready_in);
    if (pop) begin
      d.pv = 1'b1;
      d.pword = fifo_rdata;
    end else if (pixel_ready_in) begin
      d.pv = 1'b0;
    end

    // a new drop beats the clear from a falling enable
    d.ovf = (q.ovf && capture_enable_in) || (q.drop_s2 != q.drop_s3);

    if (rst_in) begin
      d = TOP_RST;
      d.pin_s1 = capture_pixel_bus_in;
      d.pin_s2 = q.pin_s1;
      d.strap = q.pin_s2;
    end
  end

  always_ff @(posedge clock_in) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  assign strobe_low = !host_port_read_n_out || !host_port_write_n_out;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_waiting;
    strobe_low && q.cnt == 2'h0 && !q.rdy_s2;
  endsequence

  sequence s_released;
    strobe_low && q.cnt == 2'h0 && q.rdy_s2;
  endsequence

  sequence s_finish;
    !strobe_low && !host_port_select_n_out ##1 host_port_select_n_out && host_rsp_valid_out;
  endsequence

  a_oe_reset_off: assert property (@(posedge clock_in) disable iff (1'b0)
    rst_in |=> !capture_pixel_bus_oe_out)
    else $error("lower byte driven during hard reset");

  a_strap_take: assert property (@(posedge clock_in) disable iff (1'b0)
    // the pin pipeline holds unknowns for the first reset edges, so wait until it has filled
    rst_in && $past(rst_in, 3) |=> subsystem_id_out == $past(capture_pixel_bus_in, 3) && !subsystem_id_valid_out)
    else $error("strap value not taken during reset");

  a_strap_keep: assert property (
    !$past(rst_in) |-> $stable(subsystem_id_out) && subsystem_id_valid_out)
    else $error("strap value changed after reset");

  a_select_covers: assert property (
    strobe_low |-> !host_port_select_n_out)
    else $error("strobe without select");

  a_strobe_excl: assert property (
    !(!host_port_read_n_out && !host_port_write_n_out))
    else $error("read and write strobes together");

  a_write_drive: assert property (
    !host_port_write_n_out |-> capture_pixel_bus_oe_out && $stable(capture_pixel_bus_out))
    else $error("write strobe without driven data");

  a_read_float: assert property (
    !host_port_read_n_out |-> !capture_pixel_bus_oe_out)
    else $error("lower byte driven during a read");

  a_strobe_min: assert property (
    $rose(strobe_low) |-> strobe_low [*3])
    else $error("strobe shorter than three cycles");

  a_wait_state: assert property (
    s_waiting |=> strobe_low)
    else $error("strobe released without wait release");

  a_ready_ends: assert property (
    s_released |=> s_finish)
    else $error("host cycle did not end after wait release");

  a_addr_hold: assert property (
    !host_port_select_n_out && $past(!host_port_select_n_out) |-> $stable(host_port_address_out))
    else $error("address moved inside a host cycle");

  a_irq_follow: assert property (
    !host_port_irq_n_in [*3] |=> interrupt_out)
    else $error("decoder interrupt not taken");

  a_dma_follow: assert property (
    dma_data_request_in [*3] |=> dma_request_out)
    else $error("dma request not passed on");

  a_no_overlap: assert property (
    !host_port_select_n_out |-> !(q.cap_en && q.cap16))
    else $error("wide capture during a host cycle");

endmodule : vcp_video_port

// [sim/vcp_far_side.sv]
// far side model: the video source on the capture pins and the decoder chip on the host port
// assumes the bench merges the shared lower byte from the enables that this model exports
`timescale 1ns/1ps
module vcp_far_side import vcp_pkg::*; (
  input wire logic clock_in,
  output logic capture_clock_out,
  output logic horizontal_reference_out,
  output logic vertical_reference_out,
  output logic capture_data_valid_out,
  output logic [PIX_W-1:0] source_bus_out,
  output logic source_low_oe_out,
  input wire logic [BYTE_W-1:0] pin_low_in,
  input wire logic [ADDR_W-1:0] host_port_address_in,
  input wire logic host_port_select_n_in,
  input wire logic host_port_read_n_in,
  input wire logic host_port_write_n_in,
  output logic [BYTE_W-1:0] decoder_data_out,
  output logic decoder_oe_out,
  output logic host_port_wait_release_out,
  output logic dma_data_request_out,
  output logic host_port_irq_n_out
);
  logic [BYTE_W-1:0] mem [32];
  int wait_cyc = 2;
  int strobe_cnt = 0;
  // ---------------------------------------------------------------
  // video source
  // ---------------------------------------------------------------
  initial begin
    capture_clock_out = 1'h0;
    forever #6 capture_clock_out = ~capture_clock_out;
  end
  initial begin
    {horizontal_reference_out, vertical_reference_out, capture_data_valid_out} = 3'h0;
    {source_bus_out, source_low_oe_out} = 17'h00000;
    {dma_data_request_out, host_port_irq_n_out} = 2'h1;
  end
  task automatic strap(input logic [PIX_W-1:0] w, input logic on);
    source_bus_out <= w;
    source_low_oe_out <= on;
  endtask : strap
  // an idle bus shows the inverse of the last word so stale data never looks valid
  task automatic send(input logic [PIX_W-1:0] w, input logic h, input logic v, input logic dv, input logic wide);
    @(posedge capture_clock_out);
    horizontal_reference_out <= h;
    vertical_reference_out <= v;
    capture_data_valid_out <= dv;
    source_bus_out <= dv ? w : ~source_bus_out;
    source_low_oe_out <= wide;
  endtask : send
  // ---------------------------------------------------------------
  // decoder chip
  // ---------------------------------------------------------------
  task automatic events(input logic irq_n, input logic dreq);
    @(posedge clock_in);
    host_port_irq_n_out <= irq_n;
    dma_data_request_out <= dreq;
  endtask : events
  always @(posedge clock_in) begin
    if (host_port_read_n_in && host_port_write_n_in) strobe_cnt <= 0;
    else strobe_cnt <= strobe_cnt + 1;
  end
  assign host_port_wait_release_out = (strobe_cnt >= wait_cyc) && !(host_port_read_n_in && host_port_write_n_in);
  assign decoder_oe_out = !host_port_select_n_in && !host_port_read_n_in;
  assign decoder_data_out = decoder_oe_out ? mem[host_port_address_in] : 8'h00;
  always @(posedge host_port_write_n_in) begin
    if (!host_port_select_n_in) mem[host_port_address_in] <= pin_low_in;
  end
endmodule : vcp_far_side

// [sim/vcp_video_port_tb.sv]
// self-checking bench of the video capture and host port
// assumes vcp_far_side stands for the video source and the decoder chip
`timescale 1ns/1ps
module vcp_video_port_tb import vcp_pkg::*;;
  logic clock_in, rst_in, cclk, hline, vref, dv, c_en, c_m16, p_rdy, h_v, h_w, rel, dreq, irq_n;
  logic poe, foe, soe, pv, pls, pfs, ovf, hrdy, hrsp, sel_n, rd_n, wr_n, dma_o, int_o, sid_v;
  logic saw_rd, saw_wr, sel_bad;
  logic [ADDR_W-1:0] h_a, ha_o, addr_seen;
  logic [BYTE_W-1:0] h_d, pout, fdat, low, rdat, byte_seen;
  logic [PIX_W-1:0] src, pdat, sid;
  int fails = 0;
  int checks_done = 0;
  // pull-downs hold the shared byte low when nobody drives it
  assign low = poe ? pout : foe ? fdat : soe ? src[BYTE_W-1:0] : 8'h00;
  vcp_video_port #(.FIFO_WORDS(FIFO_DEPTH)) uut (.clock_in(clock_in), .rst_in(rst_in), .capture_clock_in(cclk),
    .horizontal_reference_in(hline), .vertical_reference_in(vref), .capture_data_valid_in(dv),
    .capture_pixel_bus_in({src[PIX_W-1:BYTE_W], low}), .capture_pixel_bus_out(pout),
    .capture_pixel_bus_oe_out(poe), .capture_enable_in(c_en), .capture_mode16_in(c_m16),
    .pixel_valid_out(pv), .pixel_ready_in(p_rdy), .pixel_data_out(pdat), .pixel_line_start_out(pls),
    .pixel_frame_start_out(pfs), .capture_overflow_out(ovf), .host_req_valid_in(h_v), .host_req_write_in(h_w),
    .host_req_addr_in(h_a), .host_req_wdata_in(h_d), .host_req_ready_out(hrdy), .host_rsp_valid_out(hrsp),
    .host_rsp_rdata_out(rdat), .host_port_address_out(ha_o), .host_port_select_n_out(sel_n),
    .host_port_read_n_out(rd_n), .host_port_write_n_out(wr_n), .host_port_wait_release_in(rel),
    .dma_data_request_in(dreq), .host_port_irq_n_in(irq_n), .dma_request_out(dma_o), .interrupt_out(int_o),
    .subsystem_id_out(sid), .subsystem_id_valid_out(sid_v));
  vcp_far_side u_far (.clock_in(clock_in), .capture_clock_out(cclk), .horizontal_reference_out(hline),
    .vertical_reference_out(vref), .capture_data_valid_out(dv), .source_bus_out(src), .source_low_oe_out(soe),
    .pin_low_in(low), .host_port_address_in(ha_o), .host_port_select_n_in(sel_n), .host_port_read_n_in(rd_n),
    .host_port_write_n_in(wr_n), .decoder_data_out(fdat), .decoder_oe_out(foe), .host_port_wait_release_out(rel),
    .dma_data_request_out(dreq), .host_port_irq_n_out(irq_n));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic pick(input int k);
    case (k)
      0: return hrdy;
      1: return hrsp;
      default: return pv;
    endcase
  endfunction : pick
  task automatic wait_sig(input int k, input string what, output int n);
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (pick(k) !== 1'h1 && n < 200);
    if (pick(k) !== 1'h1) begin
      fails++;
      $display("ERROR %s expected high seen timeout", what);
      tally_and_finish;
    end
  endtask : wait_sig
  always @(negedge clock_in) begin
    if (!rd_n || !wr_n) begin
      saw_rd |= !rd_n;
      saw_wr |= !wr_n;
      sel_bad |= sel_n;
      addr_seen = ha_o;
      if (!wr_n) byte_seen = low;
    end
  end
  task automatic host_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d, output int lat);
    int n;
    {saw_rd, saw_wr, sel_bad} = 3'h0;
    @(posedge clock_in);
    h_v <= 1'h1;
    h_w <= wr;
    h_a <= a;
    h_d <= d;
    wait_sig(0, "host ready", n);
    @(posedge clock_in);
    h_v <= 1'h0;
    wait_sig(1, "host response", lat);
  endtask : host_op
  task automatic get_pix(input logic [PIX_W-1:0] w, input logic l, input logic f);
    int n;
    wait_sig(2, "pixel word", n);
    check("pixel data", pdat, w);
    check("line mark", 16'(pls), 16'(l));
    check("frame mark", 16'(pfs), 16'(f));
    @(posedge clock_in);
    p_rdy <= 1'h1;
    @(posedge clock_in);
    p_rdy <= 1'h0;
  endtask : get_pix
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_host;
    int lat;
    logic [ADDR_W-1:0] a;
    logic [BYTE_W-1:0] d;
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? 5'h1F : 5'h00;
      d = i[0] ? 8'hC3 : 8'h5A;
      host_op(i < 2, a, d, lat);
      check("write strobe", 16'(saw_wr), 16'(i < 2));
      check("read strobe", 16'(saw_rd), 16'(i >= 2));
      check("select off in strobe", 16'(sel_bad), 16'h0000);
      check("host address", 16'(addr_seen), 16'(a));
      if (i < 2) check("driven byte", 16'(byte_seen), 16'(d));
      else check("read byte", 16'(rdat), 16'(d));
    end
  endtask : t_host
  task automatic t_wait;
    int fast;
    int slow;
    host_op(1'h0, 5'h00, 8'h00, fast);
    u_far.wait_cyc = 7;
    host_op(1'h0, 5'h00, 8'h00, slow);
    u_far.wait_cyc = 2;
    check("added wait cycles", 16'(slow - fast), 16'h0005);
  endtask : t_wait
  task automatic t_events;
    for (int i = 0; i < 2; i++) begin
      u_far.events(i[0], !i[0]);
      repeat (5) @(negedge clock_in);
      check("interrupt", 16'(int_o), 16'(!i[0]));
      check("dma request", 16'(dma_o), 16'(!i[0]));
    end
  endtask : t_events
  task automatic t_cap8;
    @(posedge clock_in);
    c_en <= 1'h1;
    repeat (4) @(posedge cclk);
    u_far.send(16'h0000, 1'h1, 1'h1, 1'h0, 1'h0);
    u_far.send(16'hA1B2, 1'h1, 1'h1, 1'h1, 1'h0);
    u_far.send(16'h0000, 1'h0, 1'h0, 1'h0, 1'h0);
    u_far.send(16'hC3D4, 1'h0, 1'h0, 1'h1, 1'h0);
    u_far.send(16'h0000, 1'h0, 1'h0, 1'h0, 1'h0);
    get_pix(16'h00A1, 1'h1, 1'h1);
    get_pix(16'h00C3, 1'h0, 1'h0);
    repeat (20) @(negedge clock_in);
    check("no word without valid", 16'(pv), 16'h0000);
  endtask : t_cap8
  task automatic t_cap16;
    @(posedge clock_in);
    c_m16 <= 1'h1;
    repeat (8) @(negedge clock_in);
    check("host held off", 16'(hrdy), 16'h0000);
    u_far.send(16'h1234, 1'h0, 1'h0, 1'h1, 1'h1);
    u_far.send(16'hFEDC, 1'h0, 1'h0, 1'h1, 1'h1);
    u_far.send(16'h0000, 1'h0, 1'h0, 1'h0, 1'h0);
    get_pix(16'h1234, 1'h0, 1'h0);
    get_pix(16'hFEDC, 1'h0, 1'h0);
    @(posedge clock_in);
    c_m16 <= 1'h0;
  endtask : t_cap16
  task automatic t_fill;
    int n;
    logic [PIX_W-1:0] first;
    for (int i = 0; i < 24; i++) u_far.send(16'(i) << BYTE_W, 1'h0, 1'h0, 1'h1, 1'h0);
    u_far.send(16'h0000, 1'h0, 1'h0, 1'h0, 1'h0);
    repeat (20) @(negedge clock_in);
    check("overflow flag", 16'(ovf), 16'h0001);
    n = 0;
    @(posedge clock_in);
    p_rdy <= 1'h1;
    repeat (60) begin
      @(negedge clock_in);
      if (pv && p_rdy) begin
        if (n == 0) first = pdat;
        n++;
      end
    end
    check("oldest word kept", first, 16'h0000);
    check("words kept", 16'(n >= FIFO_DEPTH && n < 24), 16'h0001);
    @(posedge clock_in);
    c_en <= 1'h0;
    p_rdy <= 1'h0;
    repeat (8) @(negedge clock_in);
    check("overflow cleared", 16'(ovf), 16'h0000);
  endtask : t_fill
  initial begin
    clock_in = 1'h0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    {rst_in, h_v, h_w, c_en, c_m16, p_rdy} = 6'h20;
    h_a = 5'h00;
    h_d = 8'h00;
    u_far.strap(16'hA5C3, 1'h1);
    repeat (10) @(posedge clock_in);
    #1;
    check("lower byte released", 16'(poe), 16'h0000);
    check("select idle", 16'(sel_n), 16'h0001);
    repeat (10) @(posedge clock_in);
    rst_in <= 1'h0;
    u_far.strap(16'h0000, 1'h0);
    repeat (2) @(negedge clock_in);
    check("strap id", sid, 16'hA5C3);
    check("strap id valid", 16'(sid_v), 16'h0001);
    t_host;
    t_wait;
    t_events;
    t_cap8;
    t_cap16;
    t_fill;
    tally_and_finish;
  end
endmodule : vcp_video_port_tb
